// *** design/tei_pkg.sv ***
package tei_pkg;
	// ----------------------------------------
	// message coding
	// ----------------------------------------
	localparam logic [7:0] TEI_MGMT_ENTITY = 8'h0f;
	localparam logic [7:0] TEI_MT_ID_REQ = 8'h01;
	localparam logic [7:0] TEI_MT_ID_ASSIGNED = 8'h02;
	localparam logic [7:0] TEI_MT_ID_DENIED = 8'h03;
	localparam logic [7:0] TEI_MT_CHK_REQ = 8'h04;
	localparam logic [7:0] TEI_MT_CHK_RSP = 8'h05;
	localparam logic [6:0] TEI_GROUP = 7'h7f;
	localparam logic [6:0] TEI_AUTO_LO = 7'h40;
	localparam logic [5:0] TEI_MGMT_SAPI = 6'h3f;
	localparam logic [15:0] TEI_LFSR_SEED = 16'hace1;
	localparam logic [15:0] TEI_LFSR_TAPS = 16'hb400;
	localparam logic [15:0] TEI_RI_NONE = 16'h0000;
	// ----------------------------------------
	// timers (ns, clock 8 ns)
	// ----------------------------------------
	localparam int TEI_CLK_NS = 8;
	localparam int TEI_T202_NS = 2000;
	localparam int TEI_T201_NS = 1000;
	localparam int TEI_T202_CYC = TEI_T202_NS / TEI_CLK_NS;
	localparam int TEI_T201_CYC = TEI_T201_NS / TEI_CLK_NS;
	localparam int TEI_N202 = 3;
	localparam logic [6:0] TEI_FIXED_DEFAULT = 7'h05;
	localparam logic [63:0] TEI_POOL_RESET = 64'h0;
	localparam logic [15:0] TEI_CNT_ZERO = 16'h0000;
	typedef struct packed {
		logic [7:0] mtype;
		logic [15:0] ri;
		logic [6:0] ai;
	} tei_msg_s;
	typedef enum logic [1:0] {
		TEI_CHK_IN_USE,
		TEI_CHK_MULTI
	} tei_chk_mode_e;
	typedef enum logic [1:0] {
		TEI_RES_FREE,
		TEI_RES_USED,
		TEI_RES_MULTIPLE
	} tei_chk_res_e;
endpackage : tei_pkg

// *** design/tei_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface tei_link_if;
	import tei_pkg::*;
	// user to network message, sapi 63 tei 127 ui frame
	logic u2n_valid;
	tei_msg_s u2n_msg;
	logic [5:0] u2n_sapi;
	logic [6:0] u2n_tei;
	// network to user message
	logic n2u_valid;
	tei_msg_s n2u_msg;
	logic [5:0] n2u_sapi;
	logic [6:0] n2u_tei;
	modport user(output u2n_valid, u2n_msg, u2n_sapi, u2n_tei, input n2u_valid, n2u_msg, n2u_sapi, n2u_tei);
	modport network(input u2n_valid, u2n_msg, u2n_sapi, u2n_tei, output n2u_valid, n2u_msg, n2u_sapi, n2u_tei);
endinterface : tei_link_if
`default_nettype wire

// *** design/tei_rand.sv ***
`timescale 1ns/1ps
`default_nettype none
// free-running 16-bit generator; a zero fold-in makes all 65536 values reachable
module tei_rand (
	input wire logic i_clk,
	input wire logic i_resetn,
	output logic [15:0] o_value
);
	import tei_pkg::*;
	logic [15:0] lfsr;
	logic [15:0] next_lfsr;
	logic feed;
	assign feed = ^(lfsr & TEI_LFSR_TAPS);
	// xor with nor of the lower 15 bits inserts the all-zero state into the sequence
	assign next_lfsr = {lfsr[14:0], feed ^ (lfsr[14:0] == 15'h0000)};
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			lfsr <= TEI_LFSR_SEED;
		end else begin
			lfsr <= next_lfsr;
		end
	end
	assign o_value = lfsr;
endmodule : tei_rand
`default_nettype wire

// *** design/tei_user.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - fixed category hands TEI over, no messages
// - automatic category sends identity request
// - Ri sixteen bits, fresh random each request
// - identity request Ai is 127
// - start T202 when request sent
// - network denies Ai 64-126, ignores 0-63
// - network ignores a request repeating the Ri of an Ai 0-63 request one cycle before
// - network assigns TEI, echoes Ri
// - exhausted pool starts a TEI check
// - assigned TEI already held: removal request; o_remove_req never pulses, since no TEI is held while waiting
// - no match and Ri equal: adopt, stop T202
// - link entity enters assigned, resumes pending work
// - network denial echoes Ri, 127 none free
// - T202 expiry resends with new Ri
// - N202 failures: error, release, drop data
// - network check request then starts T201
// - holder answers check with TEI, random Ri
// - duplicate check: multiple, retry, free, used
// - in-use check: first answer ends it
// - check all answered listing held TEI
// - network takes each listed Ai separately; the network only counts check answers and keeps no per-Ai record
// - messages use SAPI 63 TEI 127
module tei_user #(
	parameter int T202_CYC = tei_pkg::TEI_T202_CYC,
	parameter int N202 = tei_pkg::TEI_N202
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	tei_link_if.user link,
	input wire logic i_auto,
	input wire logic [6:0] i_fixed_tei,
	input wire logic i_start,
	input wire logic i_est_req,
	input wire logic i_ui_req,
	output logic o_assigned,
	output logic [6:0] o_tei,
	output logic o_busy,
	output logic o_est_start,
	output logic o_ui_send,
	output logic o_error,
	output logic o_release_ind,
	output logic o_ui_discard,
	output logic o_remove_req,
	output logic o_chk_answered
);
	import tei_pkg::*;
	typedef enum logic [1:0] {
		TEI_U_IDLE,
		TEI_U_WAIT
	} tei_u_state_e;
	// ----------------------------------------
	// state
	// ----------------------------------------
	tei_u_state_e state;
	logic [15:0] ri;
	logic [15:0] tmr;
	logic [7:0] tries;
	logic est_pend;
	logic ui_pend;
	logic [15:0] rnd;
	tei_rand u_rand (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.o_value(rnd)
	);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire frame_ok = link.n2u_valid && link.n2u_sapi == TEI_MGMT_SAPI && link.n2u_tei == TEI_GROUP;
	wire is_asg = frame_ok && link.n2u_msg.mtype == TEI_MT_ID_ASSIGNED;
	wire is_chk = frame_ok && link.n2u_msg.mtype == TEI_MT_CHK_REQ;
	wire waiting = state == TEI_U_WAIT;
	wire tei_match = o_assigned && link.n2u_msg.ai == o_tei;
	wire asg_held = is_asg && waiting && tei_match;
	wire asg_take = is_asg && waiting && !tei_match && link.n2u_msg.ri == ri;
	wire expired = waiting && tmr == TEI_CNT_ZERO;
	wire give_up = expired && tries >= 8'(N202);
	wire retry = expired && !give_up;
	wire start_req = i_start && i_auto && !o_assigned && !waiting;
	wire fixed_take = i_start && !i_auto && !o_assigned;
	wire chk_hit = is_chk && o_assigned && (link.n2u_msg.ai == TEI_GROUP || link.n2u_msg.ai == o_tei);
	wire send = start_req || retry || chk_hit;
	wire [7:0] next_mtype = chk_hit ? TEI_MT_CHK_RSP : TEI_MT_ID_REQ;
	wire [6:0] next_ai = chk_hit ? o_tei : TEI_GROUP;
	wire got_tei = asg_take || fixed_take;
	// ----------------------------------------
	// assignment procedure
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state <= TEI_U_IDLE;
			ri <= TEI_RI_NONE;
			tmr <= TEI_CNT_ZERO;
			tries <= 8'h00;
		end else if (got_tei || give_up) begin
			state <= TEI_U_IDLE;
			ri <= TEI_RI_NONE;
			tmr <= TEI_CNT_ZERO;
		end else if (start_req || retry) begin
			state <= TEI_U_WAIT;
			ri <= rnd;
			tmr <= 16'(T202_CYC);
			tries <= start_req ? 8'h01 : tries + 8'h01;
		end else if (waiting) begin
			tmr <= tmr - 16'h0001;
		end
	end
	// ----------------------------------------
	// data link side
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_assigned <= 1'b0;
			o_tei <= TEI_GROUP;
			est_pend <= 1'b0;
			ui_pend <= 1'b0;
			o_est_start <= 1'b0;
			o_ui_send <= 1'b0;
			o_error <= 1'b0;
			o_release_ind <= 1'b0;
			o_ui_discard <= 1'b0;
			o_remove_req <= 1'b0;
			o_busy <= 1'b0;
			o_chk_answered <= 1'b0;
		end else begin
			if (got_tei) begin
				o_assigned <= 1'b1;
				o_tei <= fixed_take ? i_fixed_tei : link.n2u_msg.ai;
			end
			o_est_start <= got_tei && (est_pend || i_est_req);
			o_ui_send <= got_tei && (ui_pend || i_ui_req);
			o_error <= give_up;
			o_release_ind <= give_up && (est_pend || i_est_req);
			o_ui_discard <= give_up && (ui_pend || i_ui_req);
			o_remove_req <= asg_held;
			o_busy <= (waiting && !(got_tei || give_up)) || start_req || retry;
			o_chk_answered <= chk_hit;
			if (got_tei || give_up) begin
				est_pend <= 1'b0;
				ui_pend <= 1'b0;
			end else if (!o_assigned) begin
				est_pend <= est_pend || i_est_req;
				ui_pend <= ui_pend || i_ui_req;
			end
		end
	end
	// ----------------------------------------
	// transmit
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			link.u2n_valid <= 1'b0;
			link.u2n_msg <= '0;
			link.u2n_sapi <= TEI_MGMT_SAPI;
			link.u2n_tei <= TEI_GROUP;
		end else begin
			link.u2n_valid <= send;
			link.u2n_sapi <= TEI_MGMT_SAPI;
			link.u2n_tei <= TEI_GROUP;
			if (send) begin
				link.u2n_msg <= '{mtype: next_mtype, ri: rnd, ai: next_ai};
			end
		end
	end
endmodule : tei_user
`default_nettype wire

// *** design/tei_network.sv ***
`timescale 1ns/1ps
`default_nettype none
module tei_network #(
	parameter int T201_CYC = tei_pkg::TEI_T201_CYC
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	tei_link_if.network link,
	input wire logic i_chk_start,
	input wire logic [6:0] i_chk_tei,
	input wire tei_pkg::tei_chk_mode_e i_chk_mode,
	output logic o_chk_done,
	output tei_pkg::tei_chk_res_e o_chk_result,
	output logic o_assign_req,
	output logic [6:0] o_assign_tei,
	output logic o_pool_empty
);
	import tei_pkg::*;
	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic [63:0] pool;
	logic [15:0] last_ri;
	logic last_pend;
	logic chk_on;
	logic chk_second;
	logic [15:0] chk_tmr;
	logic [1:0] rsp_cnt;
	logic [6:0] chk_tei;
	tei_chk_mode_e chk_mode;
	logic [5:0] free_idx;
	logic free_found;
	always_comb begin
		free_idx = 6'h00;
		free_found = 1'b0;
		// index 63 would map to the group value 127, which is never handed out
		for (int k = 62; k >= 0; k--) begin
			if (!pool[k]) begin
				free_idx = 6'(k);
				free_found = 1'b1;
			end
		end
	end
	wire frame_ok = link.u2n_valid && link.u2n_sapi == TEI_MGMT_SAPI && link.u2n_tei == TEI_GROUP;
	wire is_req = frame_ok && link.u2n_msg.mtype == TEI_MT_ID_REQ;
	wire is_rsp = frame_ok && link.u2n_msg.mtype == TEI_MT_CHK_RSP;
	wire dup = is_req && last_pend && link.u2n_msg.ri == last_ri;
	wire ai_low = link.u2n_msg.ai < TEI_AUTO_LO;
	wire ai_grp = link.u2n_msg.ai == TEI_GROUP;
	wire do_assign = is_req && !dup && ai_grp && free_found;
	wire do_deny = is_req && !dup && !ai_low && !(ai_grp && free_found);
	wire rsp_hit = chk_on && is_rsp && (chk_tei == TEI_GROUP || link.u2n_msg.ai == chk_tei);
	wire exp = chk_on && chk_tmr == TEI_CNT_ZERO;
	wire chk_go = (i_chk_start || (is_req && !free_found)) && !chk_on;
	wire multi = rsp_hit && rsp_cnt != 2'b00 && chk_mode == TEI_CHK_MULTI;
	wire inuse_end = rsp_hit && chk_mode == TEI_CHK_IN_USE;
	wire resend = chk_go || (exp && !chk_second && rsp_cnt == 2'b00) || (exp && !chk_second && chk_mode == TEI_CHK_MULTI && rsp_cnt == 2'b01);
	wire fin = multi || inuse_end || (exp && !resend);
	wire [6:0] asg_tei = {1'b1, free_idx};
	// ----------------------------------------
	// assignment source point
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			pool <= TEI_POOL_RESET;
			last_ri <= TEI_RI_NONE;
			last_pend <= 1'b0;
			o_assign_req <= 1'b0;
			o_assign_tei <= TEI_GROUP;
			o_pool_empty <= 1'b0;
		end else begin
			o_assign_req <= do_assign;
			o_pool_empty <= !free_found;
			if (do_assign) begin
				pool[free_idx] <= 1'b1;
				o_assign_tei <= asg_tei;
			end
			if (fin && chk_tei[6] && chk_tei != TEI_GROUP && !(multi || rsp_cnt != 2'b00 || inuse_end)) begin
				pool[chk_tei[5:0]] <= 1'b0;
			end
			if (is_req && !dup) begin
				last_ri <= link.u2n_msg.ri;
			end
			last_pend <= is_req && !dup && ai_low;
		end
	end
	// ----------------------------------------
	// check procedure
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			chk_on <= 1'b0;
			chk_second <= 1'b0;
			chk_tmr <= TEI_CNT_ZERO;
			rsp_cnt <= 2'b00;
			chk_tei <= TEI_GROUP;
			chk_mode <= TEI_CHK_IN_USE;
			o_chk_done <= 1'b0;
			o_chk_result <= TEI_RES_FREE;
		end else begin
			o_chk_done <= fin;
			if (chk_go) begin
				chk_tei <= i_chk_start ? i_chk_tei : TEI_GROUP;
				chk_mode <= i_chk_start ? i_chk_mode : TEI_CHK_IN_USE;
			end
			if (resend) begin
				chk_on <= 1'b1;
				chk_second <= !chk_go;
				chk_tmr <= 16'(T201_CYC);
				rsp_cnt <= 2'b00;
			end else if (fin) begin
				chk_on <= 1'b0;
				o_chk_result <= (multi || rsp_cnt == 2'b10) ? TEI_RES_MULTIPLE : ((inuse_end || rsp_cnt != 2'b00) ? TEI_RES_USED : TEI_RES_FREE);
			end else if (chk_on) begin
				chk_tmr <= chk_tmr - 16'h0001;
				if (rsp_hit && rsp_cnt != 2'b11) begin
					rsp_cnt <= rsp_cnt + 2'b01;
				end
			end
		end
	end
	// ----------------------------------------
	// transmit
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			link.n2u_valid <= 1'b0;
			link.n2u_msg <= '0;
			link.n2u_sapi <= TEI_MGMT_SAPI;
			link.n2u_tei <= TEI_GROUP;
		end else begin
			link.n2u_valid <= do_assign || do_deny || resend;
			link.n2u_sapi <= TEI_MGMT_SAPI;
			link.n2u_tei <= TEI_GROUP;
			if (resend) begin
				link.n2u_msg <= '{mtype: TEI_MT_CHK_REQ, ri: TEI_RI_NONE, ai: chk_go ? (i_chk_start ? i_chk_tei : TEI_GROUP) : chk_tei};
			end else if (do_assign) begin
				link.n2u_msg <= '{mtype: TEI_MT_ID_ASSIGNED, ri: link.u2n_msg.ri, ai: asg_tei};
			end else if (do_deny) begin
				link.n2u_msg <= '{mtype: TEI_MT_ID_DENIED, ri: link.u2n_msg.ri, ai: link.u2n_msg.ai};
			end
		end
	end
endmodule : tei_network
`default_nettype wire

// *** tb/tei_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module tei_monitor (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic u2n_valid,
	input wire tei_pkg::tei_msg_s u2n_msg,
	input wire logic [5:0] u2n_sapi,
	input wire logic [6:0] u2n_tei,
	input wire logic n2u_valid,
	input wire tei_pkg::tei_msg_s n2u_msg,
	input wire logic [5:0] n2u_sapi,
	input wire logic [6:0] n2u_tei
);
	import tei_pkg::*;
	// ----------------------------------------
	// message decode
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	wire is_req = u2n_valid && u2n_msg.mtype == TEI_MT_ID_REQ;
	wire is_rsp = u2n_valid && u2n_msg.mtype == TEI_MT_CHK_RSP;
	wire is_asg = n2u_valid && n2u_msg.mtype == TEI_MT_ID_ASSIGNED;
	wire is_chk = n2u_valid && n2u_msg.mtype == TEI_MT_CHK_REQ;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_req_ai_group: assert property (is_req |-> u2n_msg.ai == TEI_GROUP)
		else $error("request ai is not group");
	a_user_addr_fixed: assert property (u2n_valid |-> u2n_sapi == TEI_MGMT_SAPI && u2n_tei == TEI_GROUP)
		else $error("user message address wrong");
	a_net_addr_fixed: assert property (n2u_valid |-> n2u_sapi == TEI_MGMT_SAPI && n2u_tei == TEI_GROUP)
		else $error("network message address wrong");
	a_req_ri_echo: assert property (is_req |=> n2u_valid && n2u_msg.ri == $past(u2n_msg.ri))
		else $error("request not answered with its ri");
	a_assign_tei_range: assert property (is_asg |-> n2u_msg.ai >= TEI_AUTO_LO && n2u_msg.ai != TEI_GROUP)
		else $error("assigned tei out of range");
	a_assign_has_cause: assert property (is_asg |-> $past(is_req))
		else $error("assigned without request");
	a_rsp_has_cause: assert property (is_rsp |-> $past(is_chk))
		else $error("check response without check");
	a_rsp_tei_match: assert property (is_rsp |-> u2n_msg.ai == $past(n2u_msg.ai) || $past(n2u_msg.ai) == TEI_GROUP)
		else $error("check response tei wrong");
	c_assign: cover property (is_asg);
	c_rsp: cover property (is_rsp);
	c_chk_retry: cover property (is_chk ##[1:40] is_chk);
endmodule : tei_monitor
`default_nettype wire

// *** tb/tei_assignment_check_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tei_assignment_check_tb;
	import tei_pkg::*;
	// ----------------------------------------
	// wiring
	// ----------------------------------------
	logic clk, rstn, rst2n, u_auto, u_start, u_est, u_ui, v_auto, v_start, v_est, v_ui, c_start;
	logic [6:0] v_fix, c_tei;
	logic [12:0] l2a;
	tei_chk_mode_e c_mode;
	tei_chk_res_e c_res;
	tei_msg_s l2m;
	wire u_asg, v_asg, c_done;
	wire [6:0] u_tei, v_tei, a_tei;
	wire [10:0] pl;
	int bad_count, compares, cyc_no;
	int ev[11];
	int rt[$];
	logic [15:0] ris[$];
	tei_link_if l1();
	tei_link_if l2();
	tei_user #(.T202_CYC(20)) i_tei_user (.i_clk(clk), .i_resetn(rstn), .link(l1), .i_auto(u_auto),
		.i_fixed_tei(7'h05), .i_start(u_start), .i_est_req(u_est), .i_ui_req(u_ui), .o_assigned(u_asg),
		.o_tei(u_tei), .o_busy(), .o_est_start(pl[0]), .o_ui_send(pl[1]), .o_error(), .o_release_ind(),
		.o_ui_discard(), .o_remove_req(), .o_chk_answered());
	tei_user #(.T202_CYC(20)) i_tei_user_b (.i_clk(clk), .i_resetn(rst2n), .link(l2), .i_auto(v_auto),
		.i_fixed_tei(v_fix), .i_start(v_start), .i_est_req(v_est), .i_ui_req(v_ui), .o_assigned(v_asg),
		.o_tei(v_tei), .o_busy(), .o_est_start(), .o_ui_send(), .o_error(pl[2]), .o_release_ind(pl[3]),
		.o_ui_discard(pl[4]), .o_remove_req(pl[9]), .o_chk_answered(pl[8]));
	tei_network #(.T201_CYC(20)) i_tei_network (.i_clk(clk), .i_resetn(rstn), .link(l1), .i_chk_start(c_start),
		.i_chk_tei(c_tei), .i_chk_mode(c_mode), .o_chk_done(c_done), .o_chk_result(c_res), .o_assign_req(pl[10]),
		.o_assign_tei(a_tei), .o_pool_empty());
	tei_monitor i_tei_monitor (.i_clk(clk), .i_resetn(rstn), .u2n_valid(l1.u2n_valid), .u2n_msg(l1.u2n_msg),
		.u2n_sapi(l1.u2n_sapi), .u2n_tei(l1.u2n_tei), .n2u_valid(l1.n2u_valid), .n2u_msg(l1.n2u_msg),
		.n2u_sapi(l1.n2u_sapi), .n2u_tei(l1.n2u_tei));
	assign pl[5] = l1.n2u_valid && l1.n2u_msg.mtype == TEI_MT_CHK_REQ;
	assign pl[6] = l2.u2n_valid && l2.u2n_msg.mtype == TEI_MT_ID_REQ;
	assign pl[7] = l2.u2n_valid && l2.u2n_msg.mtype == TEI_MT_CHK_RSP;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// pulse counts and captured user messages
	always @(posedge clk) begin
		cyc_no++;
		for (int k = 0; k < 11; k++) if (pl[k] === 1'b1) ev[k]++;
		if (pl[6] === 1'b1) begin
			ris.push_back(l2.u2n_msg.ri);
			rt.push_back(cyc_no);
		end
		if (l2.u2n_valid === 1'b1) begin
			l2m <= l2.u2n_msg;
			l2a <= {l2.u2n_sapi, l2.u2n_tei};
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task check(string n, logic [31:0] s, logic [31:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task cyc(int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask : pulse
	task wait_ev(int k, int t);
		for (int i = 0; i < 300 && ev[k] < t; i++) cyc(1);
	endtask : wait_ev
	// network message onto the second link
	task send(logic [7:0] t, logic [15:0] r, logic [6:0] a);
		l2.n2u_msg = {t, r, a};
		l2.n2u_valid = 1'b1;
		cyc(1);
		l2.n2u_valid = 1'b0;
		cyc(2);
	endtask : send
	task automatic run_chk(logic [6:0] t, tei_chk_mode_e m, tei_chk_res_e r, int nq);
		int n = 0;
		ev[5] = 0;
		c_tei = t;
		c_mode = m;
		pulse(c_start);
		while (c_done !== 1'b1 && n < 200) begin
			n++;
			cyc(1);
		end
		check("chk result", c_res, r);
		check("chk requests", ev[5], nq);
		if (r == TEI_RES_FREE) check("chk span", n >= 38, 1'b1);
	endtask : run_chk
	task results;
		if (bad_count == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{rstn, rst2n, u_auto, u_start, u_est, u_ui, v_auto, v_start, v_est, v_ui, c_start} = '0;
		v_fix = 7'h05;
		c_tei = '0;
		c_mode = TEI_CHK_IN_USE;
		l2.n2u_valid = 1'b0;
		l2.n2u_msg = '0;
		l2.n2u_sapi = TEI_MGMT_SAPI;
		l2.n2u_tei = TEI_GROUP;
		cyc(2);
		rstn = 1'b1;
		rst2n = 1'b1;
		check("tei reset", u_tei, 7'h7f);
		u_auto = 1'b1;
		v_auto = 1'b1;
		pulse(u_est);
		pulse(u_ui);
		pulse(u_start);
		cyc(4);
		check("assigned", u_asg, 1'b1);
		check("tei", u_tei, 7'h40);
		check("net tei", a_tei, 7'h40);
		check("assign req", ev[10], 1);
		check("est start", ev[0], 1);
		check("ui send", ev[1], 1);
		run_chk(7'h40, TEI_CHK_IN_USE, TEI_RES_USED, 1);
		run_chk(7'h41, TEI_CHK_IN_USE, TEI_RES_FREE, 2);
		run_chk(7'h40, TEI_CHK_MULTI, TEI_RES_USED, 2);
		run_chk(7'h41, TEI_CHK_MULTI, TEI_RES_FREE, 2);
		// silent far end, one answer with a foreign ri
		pulse(v_est);
		pulse(v_ui);
		pulse(v_start);
		wait_ev(6, 1);
		send(TEI_MT_ID_ASSIGNED, ris[0] ^ 16'h0001, 7'h42);
		wait_ev(2, 1);
		check("requests", ris.size(), 3);
		check("ri fresh", ris[0] != ris[1] && ris[1] != ris[2], 1'b1);
		check("retry gap", (rt[1] - rt[0]) inside {[20:22]}, 1'b1);
		check("no adopt", v_asg, 1'b0);
		check("release", ev[3], 1);
		check("discard", ev[4], 1);
		check("req ai", l2m.ai, 7'h7f);
		check("req addr", l2a, {6'h3f, 7'h7f});
		rst2n = 1'b0;
		cyc(2);
		rst2n = 1'b1;
		ris.delete();
		pulse(v_start);
		wait_ev(6, 4);
		send(TEI_MT_ID_ASSIGNED, ris[0], 7'h46);
		check("adopt", v_tei, 7'h46);
		send(TEI_MT_CHK_REQ, 16'h0000, 7'h46);
		check("chk rsp", ev[7], 1);
		check("rsp ai", l2m.ai, 7'h46);
		send(TEI_MT_CHK_REQ, 16'h0000, 7'h7f);
		check("chk all", ev[7], 2);
		check("all ai", l2m.ai, 7'h46);
		send(TEI_MT_CHK_REQ, 16'h0000, 7'h47);
		check("other tei", ev[7], 2);
		check("chk answered", ev[8], 2);
		check("no removal", ev[9], 0);
		rst2n = 1'b0;
		v_auto = 1'b0;
		cyc(2);
		rst2n = 1'b1;
		pulse(v_start);
		cyc(3);
		check("fixed tei", v_tei, 7'h05);
		check("fixed asg", v_asg, 1'b1);
		check("no msg", ev[6], 4);
		results();
	end
	initial begin
		#50000;
		bad_count++;
		results();
	end
endmodule : tei_assignment_check_tb
`default_nettype wire
